// ### common/drc_pkg.sv
// Functional notes
// R1 - Mixed or unrelated ports: one sync, one async; the code has a single request port, sync or async as set by port_async
// R2 - Sync gets early ack, async late or bus
// R3 - Advanced acks optimized; bus ack uses handshake timing
// R4 - Outside flops delay sync status before row strobe
// R5 - Test mode 1 splits counter, both advance
// R6 - Tester checks split counters, then carry separately
// R7 - Split counters drive address like scrubbing
// R8 - Test mode 1 blocks memory initialization
// R9 - Test mode 2 presets counter near rollover
// R10 - ECC test mode 2 skips initialization pass
// R11 - Refresh port serves interval and external requests
// R12 - Mode inputs sampled at reset release
`default_nettype none
package drc_pkg;
    localparam int unsigned ROW_BITS     = 9;
    localparam int unsigned LOW_BITS     = 5;
    localparam logic [8:0]  REF_RESET    = 9'h000;
    localparam logic [8:0]  REF_PRESET   = 9'h1FC;
    localparam int unsigned REF_INTERVAL = 64;
    localparam int unsigned INIT_ROWS    = 512;
    localparam int unsigned ADV_EARLY    = 1;
    localparam int unsigned ADV_LATE     = 2;
    localparam int unsigned BUS_ACK_WAIT = 2;
    localparam logic [1:0]  MODE_NORMAL  = 2'h0;
    localparam logic [1:0]  MODE_SPLIT   = 2'h1;
    localparam logic [1:0]  MODE_PRESET  = 2'h2;

    typedef enum logic [3:0] {
        DRC_IDLE   = 4'b0001,
        DRC_ROW    = 4'b0010,
        DRC_COL    = 4'b0100,
        DRC_DONE   = 4'b1000
    } drc_cycle_e;
endpackage
`default_nettype wire

// ### verilog/drc_ack_sel.sv
`default_nettype none
module drc_ack_sel (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic cycle_speed_select,
    input  wire logic port_async,
    input  wire logic use_bus_ack,
    input  wire logic is_command,
    input  wire logic start,
    input  wire logic done,
    output logic      early_advanced_acknowledge,
    output logic      late_advanced_acknowledge,
    output logic      bus_transfer_acknowledge
);
    logic [3:0] cnt;
    logic       busy;
    logic       bus_mode;

    // Bus ack only for async command cycles with use_bus_ack; speed only shifts late point
    assign bus_mode = port_async && is_command && use_bus_ack; // [R2]

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt  <= 4'h0;
            busy <= 1'b0;
        end else if (start) begin
            cnt  <= 4'h1;
            busy <= 1'b1;
        end else if (done) begin
            busy <= 1'b0;
        end else if (busy && cnt != 4'hF) begin
            cnt <= cnt + 4'h1;
        end
    end

    // Advanced acks are single pulses timed ahead of data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            early_advanced_acknowledge <= 1'b0;
            late_advanced_acknowledge  <= 1'b0;
        end else begin
            early_advanced_acknowledge <= busy && !port_async &&
                cnt == 4'(drc_pkg::ADV_EARLY); // [R2] [R3]
            late_advanced_acknowledge  <= busy && port_async && !bus_mode &&
                cnt == 4'(drc_pkg::ADV_LATE + {31'h0, cycle_speed_select}); // [R2] [R3]
        end
    end

    // Bus ack held until the cycle ends, as the bus handshake expects
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus_transfer_acknowledge <= 1'b0;
        end else begin
            bus_transfer_acknowledge <= busy && bus_mode && !done &&
                cnt >= 4'(drc_pkg::BUS_ACK_WAIT); // [R3]
        end
    end
endmodule
`default_nettype wire

// ### verilog/drc_ctrl.sv
`default_nettype none
module drc_ctrl (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] test_mode_pin,
    input  wire logic       ecc_mode,
    input  wire logic       cycle_speed_select,
    input  wire logic       port_async,
    input  wire logic       use_bus_ack,
    input  wire logic       req_pin,
    input  wire logic       req_is_command,
    input  wire logic       ext_refresh_pin,
    output logic            early_advanced_acknowledge,
    output logic            late_advanced_acknowledge,
    output logic            bus_transfer_acknowledge,
    output logic [8:0]      addr_out,
    output logic            row_strobe,
    output logic            col_strobe,
    output logic            init_active,
    output logic            refresh_active
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [1:0] req_s;
    logic [1:0] ref_s;
    logic [1:0] tm_s0;
    logic [1:0] tm_s1;
    logic [1:0] ecc_s;
    logic [3:0] cfg_s0;
    logic [3:0] cfg_s1;
    logic       ref_prev;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_s    <= 2'h0;
            ref_s    <= 2'h0;
            ref_prev <= 1'b0;
        end else begin
            req_s    <= {req_s[0], req_pin};
            ref_s    <= {ref_s[0], ext_refresh_pin};
            ref_prev <= ref_s[1];
        end
    end

    // Straps keep syncing through reset so capture sees the real pins
    always_ff @(posedge clk) begin
        tm_s0  <= test_mode_pin;
        tm_s1  <= tm_s0;
        ecc_s  <= {ecc_s[0], ecc_mode};
        cfg_s0 <= {cycle_speed_select, port_async, use_bus_ack, req_is_command};
        cfg_s1 <= cfg_s0;
    end

    // ----------------------------------------
    // Mode capture at reset release
    // ----------------------------------------
    logic [1:0] mode;
    logic       mode_valid;
    logic       ecc_cap;

    // Latched once so a tester cannot change modes mid-run
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode       <= drc_pkg::MODE_NORMAL;
            ecc_cap    <= 1'b0;
            mode_valid <= 1'b0;
        end else if (!mode_valid) begin
            mode       <= tm_s1; // [R12]
            ecc_cap    <= ecc_s[1];
            mode_valid <= 1'b1;
        end
    end

    wire split_mode  = mode == drc_pkg::MODE_SPLIT;
    wire preset_mode = mode == drc_pkg::MODE_PRESET;

    // ----------------------------------------
    // Refresh request sources
    // ----------------------------------------
    logic [7:0] interval_cnt;
    logic       ref_pending;
    logic       start_ref;
    wire        tick    = interval_cnt == 8'(drc_pkg::REF_INTERVAL - 1);
    wire        ext_req = ref_s[1] && !ref_prev;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            interval_cnt <= 8'h00;
        end else if (mode_valid) begin
            interval_cnt <= tick ? 8'h00 : interval_cnt + 8'h01;
        end
    end

    // New request wins over the clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_pending <= 1'b0;
        end else if (mode_valid && (tick || ext_req)) begin
            ref_pending <= 1'b1; // [R11]
        end else if (start_ref) begin
            ref_pending <= 1'b0;
        end
    end

    // ----------------------------------------
    // Refresh address counter
    // ----------------------------------------
    logic [8:0] ref_addr;
    logic       addr_step;
    logic       preset_done;
    localparam int unsigned HIGH_BITS = drc_pkg::ROW_BITS - drc_pkg::LOW_BITS;
    localparam int unsigned LOW_W     = drc_pkg::LOW_BITS;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_addr    <= drc_pkg::REF_RESET;
            preset_done <= 1'b0;
        end else if (mode_valid && preset_mode && !preset_done) begin
            ref_addr    <= drc_pkg::REF_PRESET; // [R9]
            preset_done <= 1'b1;
        end else if (addr_step && split_mode) begin
            // No carry between halves while split
            ref_addr <= {ref_addr[8 -: HIGH_BITS] + HIGH_BITS'(1),
                         ref_addr[LOW_W-1:0] + LOW_W'(1)}; // [R5]
        end else if (addr_step) begin
            ref_addr <= ref_addr + 9'h001;
        end
    end

    // ----------------------------------------
    // Initialization pass
    // ----------------------------------------
    logic [9:0] init_cnt;
    logic       init_done;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            init_active <= 1'b0;
            init_done   <= 1'b0;
            init_cnt    <= 10'h000;
        end else if (mode_valid && !init_done) begin
            init_done   <= 1'b1;
            // Split mode means no ECC; preset mode skips the pass for fast reset
            init_active <= ecc_cap && !split_mode && !preset_mode; // [R8] [R10]
        end else if (init_active && addr_step) begin
            init_cnt <= init_cnt + 10'h001;
            if (init_cnt == 10'(drc_pkg::INIT_ROWS - 1)) begin
                init_active <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Memory cycle sequencer
    // ----------------------------------------
    drc_pkg::drc_cycle_e state;
    logic                is_ref;
    logic                done;
    logic                req_served;
    wire                 start_mem = state == drc_pkg::DRC_IDLE && req_s[1] && !ref_pending
                                     && !init_active && mode_valid && !req_served;
    assign start_ref = state == drc_pkg::DRC_IDLE && mode_valid && (ref_pending || init_active);
    assign addr_step = state == drc_pkg::DRC_DONE && is_ref;
    assign done      = state == drc_pkg::DRC_DONE;

    // Level request outlives its cycle by the sync delay; serve it only once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_served <= 1'b0;
        end else if (done && !is_ref) begin
            req_served <= 1'b1;
        end else if (!req_s[1]) begin
            req_served <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state  <= drc_pkg::DRC_IDLE;
            is_ref <= 1'b0;
        end else begin
            unique case (state)
                drc_pkg::DRC_IDLE: begin
                    if (start_ref || start_mem) begin
                        state  <= drc_pkg::DRC_ROW;
                        is_ref <= start_ref;
                    end
                end
                drc_pkg::DRC_ROW:  state <= drc_pkg::DRC_COL;
                drc_pkg::DRC_COL:  state <= drc_pkg::DRC_DONE;
                drc_pkg::DRC_DONE: state <= drc_pkg::DRC_IDLE;
                default:           state <= drc_pkg::DRC_IDLE;
            endcase
        end
    end

    // Same row/column timing for split or whole counter, as in scrubbing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_out       <= 9'h000;
            row_strobe     <= 1'b0;
            col_strobe     <= 1'b0;
            refresh_active <= 1'b0;
        end else begin
            row_strobe     <= state == drc_pkg::DRC_ROW || state == drc_pkg::DRC_COL;
            col_strobe     <= state == drc_pkg::DRC_COL;
            refresh_active <= state != drc_pkg::DRC_IDLE && is_ref;
            if (state == drc_pkg::DRC_ROW && is_ref) begin
                addr_out <= ref_addr; // [R7]
            end else if (state == drc_pkg::DRC_COL && is_ref) begin
                addr_out <= ref_addr; // [R7]
            end
        end
    end

    // ----------------------------------------
    // Acknowledge generation
    // ----------------------------------------
    drc_ack_sel u_ack (
        .clk                        (clk),
        .rst                        (rst),
        .cycle_speed_select         (cfg_s1[3]),
        .port_async                 (cfg_s1[2]),
        .use_bus_ack                (cfg_s1[1]),
        .is_command                 (cfg_s1[0]),
        .start                      (start_mem),
        .done                       (done && !is_ref),
        .early_advanced_acknowledge (early_advanced_acknowledge),
        .late_advanced_acknowledge  (late_advanced_acknowledge),
        .bus_transfer_acknowledge   (bus_transfer_acknowledge)
    );
endmodule
`default_nettype wire

// ### test/drc_ctrl_props.sv
`default_nettype none
module drc_ctrl_props (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [1:0] test_mode_pin,
    input wire logic       port_async,
    input wire logic       use_bus_ack,
    input wire logic       req_pin,
    input wire logic       req_is_command,
    input wire logic       early_advanced_acknowledge,
    input wire logic       late_advanced_acknowledge,
    input wire logic       bus_transfer_acknowledge,
    input wire logic [8:0] addr_out,
    input wire logic       row_strobe,
    input wire logic       init_active,
    input wire logic       col_strobe,
    input wire logic       refresh_active
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Refresh address history
    // ----
    logic [8:0] prev;
    logic       seen;
    logic       row_q;
    logic       ref_go;
    // Init is skipped: it may walk the counter unseen
    assign ref_go = refresh_active && row_strobe && !row_q && !init_active;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev  <= 9'h000;
            seen  <= 1'b0;
            row_q <= 1'b0;
        end else begin
            row_q <= row_strobe;
            if (ref_go) begin
                prev <= addr_out;
                seen <= 1'b1;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    split_step_a: assert property (
        ref_go && seen && test_mode_pin == drc_pkg::MODE_SPLIT |->
        addr_out[4:0] == prev[4:0] + 5'h01 && addr_out[8:5] == prev[8:5] + 4'h1)
        else $error("split step wrong");
    refresh_step_a: assert property (
        ref_go && seen && test_mode_pin != drc_pkg::MODE_SPLIT |->
        addr_out == prev + 9'h001)
        else $error("refresh step wrong");
    preset_first_a: assert property (
        ref_go && !seen && test_mode_pin == drc_pkg::MODE_PRESET |->
        addr_out == drc_pkg::REF_PRESET)
        else $error("preset value wrong");
    ack_single_a: assert property (
        $onehot0({early_advanced_acknowledge, late_advanced_acknowledge,
                  bus_transfer_acknowledge}))
        else $error("two acks at once");
    early_ack_a: assert property (
        early_advanced_acknowledge |-> req_pin && !port_async
        ##1 !early_advanced_acknowledge)
        else $error("early ack misplaced");
    late_ack_a: assert property (
        late_advanced_acknowledge |-> port_async && !(use_bus_ack && req_is_command)
        ##1 !late_advanced_acknowledge)
        else $error("late ack misplaced");
    bus_ack_a: assert property (
        $rose(bus_transfer_acknowledge) |-> port_async && use_bus_ack && req_is_command)
        else $error("bus ack misplaced");
    strobe_order_a: assert property (
        $rose(col_strobe) |-> row_strobe && $past(row_strobe))
        else $error("column before row");
endmodule
bind drc_ctrl drc_ctrl_props props_u (
    .clk, .rst, .test_mode_pin, .port_async, .use_bus_ack, .req_pin, .req_is_command,
    .early_advanced_acknowledge, .late_advanced_acknowledge, .bus_transfer_acknowledge,
    .addr_out, .row_strobe, .init_active, .col_strobe, .refresh_active
);
`default_nettype wire

// ### test/drc_proc_model.sv
`default_nettype none
module drc_proc_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic       cmd,
    input  wire logic [2:0] acks,
    output logic            req_pin,
    output logic            req_is_command,
    output logic            done,
    output logic [1:0]      kind
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // Requester
    // ----
    initial begin
        {req_pin, req_is_command, done, kind} = '0;
    end
    // Request comes from a flop, so address is settled first
    always @(posedge clk) begin
        done <= 1'b0;
        if (go && !req_pin) begin
            req_pin        <= 1'b1;
            req_is_command <= cmd;
        end else if (req_pin && acks != 3'h0) begin
            req_pin        <= 1'b0;
            done           <= 1'b1;
            kind           <= acks[2] ? 2'h3 : acks[1] ? 2'h2 : 2'h1;
            // Released line shows the inverse, never a held value
            req_is_command <= ~req_is_command;
        end
    end
endmodule
`default_nettype wire

// ### test/dram_dual_port_ack_and_test_modes_bench.sv
`default_nettype none
module dram_dual_port_ack_and_test_modes_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst, ecc_mode, cycle_speed_select, port_async, use_bus_ack;
    logic       ext_refresh_pin, go, cmd, req_pin, req_is_command, done;
    logic       early_advanced_acknowledge, late_advanced_acknowledge;
    logic       bus_transfer_acknowledge, row_strobe, col_strobe, init_active;
    logic       refresh_active;
    logic [1:0] test_mode_pin, kind;
    logic [8:0] addr_out;
    int         failures, compares, seed, n, r;

    drc_ctrl dut_u (
        .clk, .rst, .test_mode_pin, .ecc_mode, .cycle_speed_select, .port_async,
        .use_bus_ack, .req_pin, .req_is_command, .ext_refresh_pin,
        .early_advanced_acknowledge, .late_advanced_acknowledge,
        .bus_transfer_acknowledge, .addr_out, .row_strobe, .col_strobe,
        .init_active, .refresh_active
    );
    drc_proc_model model_u (
        .clk, .go, .cmd, .req_pin, .req_is_command, .done, .kind,
        .acks({bus_transfer_acknowledge, late_advanced_acknowledge,
               early_advanced_acknowledge})
    );
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ----
    // Checking helpers
    // ----
    function automatic logic [1:0] exp_kind(input logic a, input logic c, input logic b);
        return !a ? 2'h1 : (b && c) ? 2'h3 : 2'h2;
    endfunction
    task automatic check(input string what, input logic [1:0] exp, input logic [1:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic start(input logic [1:0] m, input logic e);
        @(posedge clk);
        rst           <= 1'b1;
        test_mode_pin <= m;
        ecc_mode      <= e;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(negedge clk);
    endtask
    task automatic request(input logic a, input logic c, input logic b, input logic s);
        @(posedge clk);
        port_async         <= a;
        cmd                <= c;
        use_bus_ack        <= b;
        cycle_speed_select <= s;
        go                 <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (!done && n < 200);
        check("ack seen", 2'h1, {1'b0, done});
        check("ack kind", exp_kind(a, c, b), kind);
        repeat (4) @(posedge clk);
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        seed          = 32'h8f26_d69f;
        failures      = 0;
        compares      = 0;
        rst           = 1'b1;
        test_mode_pin = 2'h0;
        {ecc_mode, cycle_speed_select, port_async, use_bus_ack, ext_refresh_pin} = '0;
        {go, cmd} = '0;
        repeat (20) @(posedge clk);
        for (int m = 0; m < 3; m++) begin
            for (int e = 0; e < 2; e++) begin
                start(2'(m), e[0]);
                check("init", {1'b0, m == 0 && e == 1}, {1'b0, init_active});
                n = 0;
                while (init_active !== 1'b0 && n < 5000) begin
                    @(negedge clk);
                    n++;
                end
                check("init end", 2'h0, {1'b0, init_active});
                // Tester steps the counter by hand
                repeat (3) begin
                    @(posedge clk);
                    ext_refresh_pin <= 1'b1;
                    repeat (3) @(posedge clk);
                    ext_refresh_pin <= 1'b0;
                    repeat (8) @(posedge clk);
                end
                // All eight corners first, then random; one port either kind
                for (int k = 0; k < 12; k++) begin
                    r = (k < 8) ? k : $random(seed);
                    n = $random(seed);
                    request(r[0], r[1], r[2], n[3]);
                end
                repeat (100) @(posedge clk);
                $display("mode %0d ecc %0d finished", m, e);
            end
        end
        conclude();
    end
    initial begin
        #200000;
        failures++;
        conclude();
    end
endmodule
`default_nettype wire
